// [design/elp_pkg.sv]
// package for the eprom line read protection block
// assumes a 16 kbyte eprom array with byte-wide access
package elp_pkg;
  // ---------------------------------------------------------------
  // array geometry
  // ---------------------------------------------------------------
  localparam int unsigned ELP_ADDR_W     = 14;
  localparam int unsigned ELP_DATA_W     = 8;
  localparam int unsigned ELP_HALF_BYTES = 32;                 // bytes per matrix line
  localparam int unsigned ELP_LINE_BYTES = 2 * ELP_HALF_BYTES; // bytes per combined line
  localparam int unsigned ELP_LINE_SHIFT = 6;                  // log2 of line bytes
  localparam int unsigned ELP_LINE_W     = ELP_ADDR_W - ELP_LINE_SHIFT;
  localparam int unsigned ELP_LINES      = 1 << ELP_LINE_W;
  localparam int unsigned ELP_HALF_W     = ELP_ADDR_W - 1;
  localparam int unsigned ELP_LANE_BIT   = 0;                  // address bit that picks the matrix
  localparam int unsigned ELP_SEC_WR_BIT = 0;                  // data bit of a security write

  // ---------------------------------------------------------------
  // values
  // ---------------------------------------------------------------
  localparam logic [ELP_DATA_W-1:0] ELP_BLANK_DATA = 8'hFF;  // erased cell
  localparam logic [ELP_DATA_W-1:0] ELP_ZERO_DATA  = 8'h00;  // answer for guarded lines
  localparam logic                  ELP_SEC_OPEN   = 1'h1;   // unprogrammed security bit
  localparam logic                  ELP_SEC_SHUT   = 1'h0;   // programmed security bit

  // ---------------------------------------------------------------
  // programming mode pin decode
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ELP_PM_NORMAL   = 2'h3,
    ELP_PM_SECURITY = 2'h1
  } elp_pm_t;
endpackage

// [design/elp_matrix.sv]
// one half of the eprom array: even or odd byte addresses
// assumes one write or read per cycle; read data registered
`timescale 1ns/1ps
`default_nettype none
module elp_matrix
  import elp_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  wr_en,
  input  wire logic [ELP_HALF_W-1:0] addr,
  input  wire logic [ELP_DATA_W-1:0] wr_data,
  output logic      [ELP_DATA_W-1:0] rd_data_ff
);
  // cells start erased, as a fresh eprom does; not touched by reset
  logic [ELP_DATA_W-1:0] cell_mem [0:(1<<ELP_HALF_W)-1] = '{default: ELP_BLANK_DATA};

  // programming only clears bits, as an eprom cell does
  always_ff @(posedge core_clk) begin
    if (wr_en) begin
      cell_mem[addr] <= cell_mem[addr] & wr_data;
    end
    rd_data_ff <= cell_mem[addr];
  end
endmodule
`default_nettype wire

// [design/elp_protect.sv]
// eprom array with per-line read protection, programming port and cpu port
// assumes prog and cpu ports are synchronous to core_clk; cpu reports
// the region of each executed instruction on fetch_valid
// array cells and security bits keep their contents through reset,
// as non-volatile storage does
`timescale 1ns/1ps
`default_nettype none
module elp_protect
  import elp_pkg::*;
(
  input  wire logic                  core_clk,
  input  wire logic                  reset_n,
  input  wire logic                  prog_mode,
  input  wire logic                  prog_mode_select_a,
  input  wire logic                  prog_mode_select_b,
  input  wire logic                  prog_wr,
  input  wire logic                  prog_rd,
  input  wire logic [ELP_ADDR_W-1:0] prog_addr,
  input  wire logic [ELP_DATA_W-1:0] prog_wr_data,
  output logic      [ELP_DATA_W-1:0] prog_rd_data_ff,
  output logic                       prog_rd_valid_ff,
  input  wire logic                  cpu_rd,
  input  wire logic [ELP_ADDR_W-1:0] cpu_addr,
  output logic      [ELP_DATA_W-1:0] cpu_rd_data_ff,
  output logic                       cpu_rd_valid_ff,
  output logic                       cpu_rd_refused_ff,
  input  wire logic                  fetch_valid,
  input  wire logic                  fetch_outside,
  output logic                       lockout_ff
);
  // ---------------------------------------------------------------
  // mode decode
  // ---------------------------------------------------------------
  // pin code only counts in programming mode; unknown codes drop writes
  wire elp_pm_t pin_mode   = elp_pm_t'({prog_mode_select_b, prog_mode_select_a});
  wire logic    pm_normal  = prog_mode && (pin_mode == ELP_PM_NORMAL);
  wire logic    pm_secure  = prog_mode && (pin_mode == ELP_PM_SECURITY);
  wire logic    cpu_active = !prog_mode;

  // ---------------------------------------------------------------
  // address selection
  // ---------------------------------------------------------------
  // one address path serves both ports: the mode picks the source
  wire logic                  any_go   = prog_mode ? (prog_rd || prog_wr) : cpu_rd;
  wire logic [ELP_ADDR_W-1:0] sel_addr = prog_mode ? prog_addr : cpu_addr;
  wire logic [ELP_LINE_W-1:0] line_idx = sel_addr[ELP_ADDR_W-1:ELP_LINE_SHIFT];
  // security bit addressed by any byte of the line: offset bits are ignored
  wire logic                  sec_hit  = pm_secure && prog_wr;
  wire logic                  sec_wbit = prog_wr_data[ELP_SEC_WR_BIT];
  wire logic                  sec_clr  = sec_hit && (sec_wbit == ELP_SEC_SHUT);
  wire logic                  code_wr  = pm_normal && prog_wr;
  // the lowest address bit picks the matrix, the rest address inside it
  wire logic                  odd_sel  = sel_addr[ELP_LANE_BIT];
  wire logic [ELP_HALF_W-1:0] half_adr = sel_addr[ELP_ADDR_W-1:ELP_LANE_BIT+1];

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  // one security cell per combined line, erased at start of life
  logic [ELP_LINES-1:0]  sec_bits_ff = '1;
  // first stage of the read pipeline
  logic                  sec_rd_ff;
  logic                  odd_rd_ff;
  logic                  prog_pend_ff;
  logic                  cpu_pend_ff;
  logic                  cpu_deny_ff;
  // registered read data of the two matrices
  logic [ELP_DATA_W-1:0] even_q;
  logic [ELP_DATA_W-1:0] odd_q;

  // a locked cpu is refused outright; lockout needs an outside fetch while
  // any line of the array is guarded, and reads taken on that same edge
  // are still granted
  wire logic line_open  = (sec_bits_ff[line_idx] == ELP_SEC_OPEN);
  wire logic cpu_refuse = lockout_ff;
  wire logic cpu_grant  = cpu_rd && cpu_active && !cpu_refuse;
  wire logic nxt_lockout = lockout_ff ||
                           (cpu_active && fetch_valid && fetch_outside &&
                            !(&sec_bits_ff));

  // ---------------------------------------------------------------
  // two byte matrices
  // ---------------------------------------------------------------
  // code writes only in normal mode, steered by the byte lane
  wire logic even_wr = code_wr && !odd_sel;
  wire logic odd_wr  = code_wr && odd_sel;

  elp_matrix u_even (
    .core_clk   (core_clk),
    .wr_en      (even_wr),
    .addr       (half_adr),
    .wr_data    (prog_wr_data),
    .rd_data_ff (even_q)
  );

  elp_matrix u_odd (
    .core_clk   (core_clk),
    .wr_en      (odd_wr),
    .addr       (half_adr),
    .wr_data    (prog_wr_data),
    .rd_data_ff (odd_q)
  );

  // lane picked by the registered address bit, in step with the data
  wire logic [ELP_DATA_W-1:0] arr_q = odd_rd_ff ? odd_q : even_q;

  // ---------------------------------------------------------------
  // security bits and lockout
  // ---------------------------------------------------------------
  // security cells live in the eprom and are never reset;
  // a cell only goes from open to shut, so a guard cannot be undone
  always_ff @(posedge core_clk) begin
    if (sec_clr) begin
      sec_bits_ff[line_idx] <= ELP_SEC_SHUT;
    end
  end

  // lockout sticks until reset
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      lockout_ff <= 1'b0;
    end else begin
      lockout_ff <= nxt_lockout;
    end
  end

  // ---------------------------------------------------------------
  // read pipeline, first stage
  // ---------------------------------------------------------------
  // a read and a write in one cycle count as a write only
  wire logic nxt_prog_pend = prog_mode && prog_rd && !prog_wr;
  wire logic nxt_cpu_pend  = cpu_grant;
  wire logic nxt_cpu_deny  = cpu_rd && cpu_active && cpu_refuse;
  // line state is taken with the address, beside the array read
  wire logic nxt_sec_rd    = line_open;
  wire logic nxt_odd_rd    = odd_sel && any_go;

  // programmer request flag
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prog_pend_ff <= 1'b0;
    end else begin
      prog_pend_ff <= nxt_prog_pend;
    end
  end

  // cpu request flags, grant and refusal never both set
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_pend_ff <= 1'b0;
      cpu_deny_ff <= 1'b0;
    end else begin
      cpu_pend_ff <= nxt_cpu_pend;
      cpu_deny_ff <= nxt_cpu_deny;
    end
  end

  // line state and byte lane of the access in flight
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      sec_rd_ff <= ELP_SEC_OPEN;
      odd_rd_ff <= 1'b0;
    end else begin
      sec_rd_ff <= nxt_sec_rd;
      odd_rd_ff <= nxt_odd_rd;
    end
  end

  // ---------------------------------------------------------------
  // read answers
  // ---------------------------------------------------------------
  // outside the valid cycle both data buses rest at 00, and the programmer bus also for guarded lines,
  // so a guarded byte never reaches the programmer pins even for one cycle
  wire logic                  prog_show     = prog_pend_ff && (sec_rd_ff == ELP_SEC_OPEN);
  wire logic [ELP_DATA_W-1:0] nxt_prog_data = prog_show ? arr_q : ELP_ZERO_DATA;
  wire logic [ELP_DATA_W-1:0] nxt_cpu_data  = cpu_pend_ff ? arr_q : ELP_ZERO_DATA;

  // programmer answer
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      prog_rd_valid_ff <= 1'b0;
      prog_rd_data_ff  <= ELP_ZERO_DATA;
    end else begin
      prog_rd_valid_ff <= prog_pend_ff;
      prog_rd_data_ff  <= nxt_prog_data;
    end
  end

  // cpu answer
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_rd_valid_ff <= 1'b0;
      cpu_rd_data_ff  <= ELP_ZERO_DATA;
    end else begin
      cpu_rd_valid_ff <= cpu_pend_ff;
      cpu_rd_data_ff  <= nxt_cpu_data;
    end
  end

  // cpu refusal pulse, one cycle per refused read
  always_ff @(posedge core_clk or negedge reset_n) begin
    if (!reset_n) begin
      cpu_rd_refused_ff <= 1'b0;
    end else begin
      cpu_rd_refused_ff <= cpu_deny_ff;
    end
  end
endmodule
`default_nettype wire

// [testbench/elp_monitor.sv]
// checker on the eprom read protection ports
// assumes bind to elp_protect, one clock domain
`timescale 1ns/1ps
`default_nettype none
module elp_monitor
  import elp_pkg::*;
(
  input wire logic                  core_clk,
  input wire logic                  reset_n,
  input wire logic                  prog_mode,
  input wire logic                  prog_rd,
  input wire logic                  prog_wr,
  input wire logic                  cpu_rd,
  input wire logic                  fetch_valid,
  input wire logic                  fetch_outside,
  input wire logic [ELP_DATA_W-1:0] prog_rd_data_ff,
  input wire logic                  prog_rd_valid_ff,
  input wire logic [ELP_DATA_W-1:0] cpu_rd_data_ff,
  input wire logic                  cpu_rd_valid_ff,
  input wire logic                  cpu_rd_refused_ff,
  input wire logic                  lockout_ff
);
  // ---------------------------------------------------------------
  // port relations
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!reset_n);
  a_prog_rd_answer: assert property (prog_mode && prog_rd && !prog_wr |-> ##2 prog_rd_valid_ff)
    else $error("programmer read not answered in two cycles");
  a_cpu_rd_grant: assert property (!prog_mode && cpu_rd && !lockout_ff |-> ##2 (cpu_rd_valid_ff && !cpu_rd_refused_ff))
    else $error("cpu read before lockout not granted");
  a_cpu_rd_refuse: assert property (!prog_mode && cpu_rd && lockout_ff |-> ##2 (cpu_rd_refused_ff && !cpu_rd_valid_ff))
    else $error("cpu read after lockout not refused");
  a_lock_holds: assert property (lockout_ff |=> lockout_ff)
    else $error("lockout dropped without reset");
  a_lock_cause: assert property ($rose(lockout_ff) |-> $past(fetch_valid && fetch_outside && !prog_mode))
    else $error("lockout set without outside fetch");
  a_inside_no_lock: assert property (fetch_valid && !fetch_outside && !lockout_ff |=> !lockout_ff)
    else $error("inside fetch set lockout");
  a_prog_idle_zero: assert property (!prog_rd_valid_ff |-> prog_rd_data_ff == 8'h00)
    else $error("programmer data not zero when idle");
  a_cpu_idle_zero: assert property (!cpu_rd_valid_ff |-> cpu_rd_data_ff == 8'h00)
    else $error("cpu data not zero when idle");
  c_lock: cover property ($rose(lockout_ff));
  c_refused: cover property (cpu_rd_refused_ff);
  c_prog_rd: cover property (prog_rd_valid_ff);
endmodule
bind elp_protect elp_monitor u_elp_monitor (.*);
`default_nettype wire

// [testbench/elp_prog_model.sv]
// programmer side pin driver for mode selection
// assumes sec_sel is set by the bench before each programming access
`timescale 1ns/1ps
`default_nettype none
module elp_prog_model (
  input  wire logic sec_sel,
  output logic      sel_a,
  output logic      sel_b
);
  // a=1,b=1 normal; a=1,b=0 security
  assign sel_a = 1'h1;
  assign sel_b = ~sec_sel;
endmodule
`default_nettype wire

// [testbench/testbench.sv]
// self-checking bench for elp_protect
// assumes erased array at start and 4 ns clock
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import elp_pkg::*;
  logic core_clk, reset_n, prog_mode, sec_sel, prog_wr, prog_rd, cpu_rd, fetch_valid;
  logic fetch_outside, prog_rd_valid_ff, cpu_rd_valid_ff, cpu_rd_refused_ff, lockout_ff;
  logic prog_mode_select_a, prog_mode_select_b;
  logic [13:0] prog_addr, cpu_addr, a, base;
  logic [7:0]  prog_wr_data, prog_rd_data_ff, cpu_rd_data_ff;
  logic [7:0]  mem [16384];
  logic        secb [256];
  int          failures, n_checks, cycles;
  elp_protect u_elp_protect (.*);
  elp_prog_model u_elp_prog_model (.sec_sel(sec_sel), .sel_a(prog_mode_select_a), .sel_b(prog_mode_select_b));
  initial begin
    core_clk = 0;
    forever #2 core_clk = ~core_clk;
  end
  // hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      wrap_up();
    end
  end
  task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", w, e, g);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic do_reset();
    reset_n = 0;
    repeat (3) @(negedge core_clk);
    reset_n = 1;
  endtask
  // one programmer access; read data is checked in its valid cycle
  task automatic prog_op(input logic wr, input logic s, input logic [13:0] ad, input logic [7:0] dd);
    logic [7:0] e;
    e = secb[ad[13:6]] ? mem[ad] : 8'h00;
    @(negedge core_clk);
    {prog_mode, sec_sel, prog_wr, prog_rd, prog_addr, prog_wr_data} = {1'b1, s, wr, !wr, ad, dd};
    if (wr && s && !dd[0]) secb[ad[13:6]] = 0;
    if (wr && !s) mem[ad] &= dd;
    @(negedge core_clk);
    {prog_wr, prog_rd} = 2'b00;
    @(negedge core_clk);
    if (!wr) chk("prog_valid", 8'h01, {7'h00, prog_rd_valid_ff});
    if (!wr) chk("prog_data", e, prog_rd_data_ff);
  endtask
  task automatic cpu_op(input logic [13:0] ad, input logic r);
    @(negedge core_clk);
    {prog_mode, cpu_rd, cpu_addr} = {2'b01, ad};
    @(negedge core_clk);
    cpu_rd = 0;
    @(negedge core_clk);
    chk("cpu_refused", {7'h00, r}, {7'h00, cpu_rd_refused_ff});
    chk("cpu_valid", {7'h00, !r}, {7'h00, cpu_rd_valid_ff});
    chk("lockout", {7'h00, r}, {7'h00, lockout_ff});
    chk("cpu_data", r ? 8'h00 : mem[ad], cpu_rd_data_ff);
  endtask
  task automatic fetch(input logic o);
    @(negedge core_clk);
    {prog_mode, fetch_valid, fetch_outside} = {2'b01, o};
    @(negedge core_clk);
    fetch_valid = 0;
  endtask
  initial begin
    void'($urandom(32'h4447d92a));
    {prog_mode, sec_sel, prog_wr, prog_rd, cpu_rd, fetch_valid, fetch_outside} = 0;
    {prog_addr, cpu_addr, prog_wr_data} = 0;
    foreach (mem[i]) mem[i] = 8'hFF;
    foreach (secb[i]) secb[i] = 1;
    do_reset();
    // random code writes, edge addresses included
    for (int i = 0; i < 16; i++) begin
      a = (i == 0) ? 14'h0000 : (i == 1) ? 14'h3FFF : 14'($urandom);
      prog_op(1, 0, a, 8'($urandom));
      prog_op(0, 0, a, 8'h00);
      cpu_op(a, 0);
    end
    $display("test code_rw done");
    base = {8'($urandom % 255), 6'h00};
    prog_op(1, 0, base, 8'h5A);
    prog_op(1, 1, base, 8'hFE);
    prog_op(1, 1, base + 14'h0041, 8'h01);
    for (int i = 0; i < 8; i++) prog_op(0, 0, base + 14'(i * 9), 8'h00);
    prog_op(0, 0, base + 14'h003F, 8'h00);
    prog_op(0, 0, base + 14'h0041, 8'h00);
    $display("test guard_line done");
    cpu_op(base, 0);
    fetch(0);
    cpu_op(base + 14'h0001, 0);
    fetch(1);
    cpu_op(base + 14'h0040, 1);
    cpu_op(base, 1);
    do_reset();
    cpu_op(base, 0);
    $display("test cpu_lock done");
    wrap_up();
  end
endmodule
`default_nettype wire
